// [common/ledcmd_pkg.sv]
// shared constants, field positions and types for the led colour command decoder
package ledcmd_pkg;
  // frame identifiers and expected data byte counts
  localparam logic [7:0] ID_LED_CONTROL = 8'hA3;
  localparam logic [7:0] ID_COLOR = 8'h64;
  localparam logic [7:0] ID_COLOR_SHORT = 8'h6F;
  localparam logic [3:0] LEN_LED_CONTROL = 4'h4;
  localparam logic [3:0] LEN_COLOR = 4'h8;
  localparam logic [3:0] LEN_COLOR_SHORT = 4'h4;
  localparam logic [3:0] BUF_DEPTH = 4'h8;
  localparam logic [3:0] RX_CNT_OVF = 4'h9;
  localparam logic [7:0] CSUM_ALL_ONES = 8'hFF;
  // data byte positions in the receive buffer
  localparam int IDX_D1 = 0;
  localparam int IDX_D2 = 1;
  localparam int IDX_D3 = 2;
  localparam int IDX_D4 = 3;
  localparam int IDX_D5 = 4;
  localparam int IDX_D6 = 5;
  localparam int IDX_D7 = 6;
  localparam int IDX_D8 = 7;
  // addressing byte
  localparam int ADDR_MODE_BIT = 7;
  localparam int AD_MSB = 5;
  // control byte
  localparam int CTRL_CAL_EN = 7;
  localparam int CTRL_MOD_FREQ = 6;
  localparam int CTRL_LEDS_ON = 5;
  localparam int CTRL_THERM = 4;
  localparam int CTRL_LED3 = 3;
  localparam int CTRL_LED1 = 1;
  localparam logic [7:0] RST_CTRL = 8'h01;
  // colour frame fields
  localparam int POLICY_MSB = 7;
  localparam int POLICY_LSB = 6;
  localparam int FTIME_MSB = 5;
  localparam int FADE_ON_BIT = 7;
  localparam int FADE_SLOPE_BIT = 6;
  localparam int CLR_LEDS_ON_BIT = 5;
  localparam int INTENS_MSB = 3;
  localparam logic [3:0] SHORT_MARK = 4'hF;
  typedef enum logic [1:0] {
    POL_IMMEDIATE = 2'h0,
    POL_STORE = 2'h1,
    POL_RECALL = 2'h2,
    POL_DISCARD = 2'h3
  } update_policy_t;
  // calibration arithmetic
  localparam int CAL_SHIFT = 7;
  localparam logic [10:0] MOD_MAX = 11'h7FF;
  localparam logic [23:0] RST_CAL_ROW1 = 24'h000080;
  localparam logic [23:0] RST_CAL_ROW2 = 24'h008000;
  localparam logic [23:0] RST_CAL_ROW3 = 24'h800000;
  localparam logic [5:0] RST_NODE_ADDR = 6'h00;
  localparam logic [3:0] RST_MEMBERSHIP = 4'h0;
  // register map
  localparam logic [7:0] REG_NODE_CFG = 8'h00;
  localparam logic [7:0] REG_CAL_ROW1 = 8'h04;
  localparam logic [7:0] REG_CAL_ROW2 = 8'h08;
  localparam logic [7:0] REG_CAL_ROW3 = 8'h0C;
  localparam logic [7:0] REG_CONTROL = 8'h10;
  localparam logic [7:0] REG_COLORS = 8'h14;
  localparam logic [7:0] REG_MOD12 = 8'h18;
  localparam logic [7:0] REG_MOD3 = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam int CFG_MEMB_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_DATA = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } lin_rx_t;

  typedef struct packed {
    logic leds_on;
    logic [2:0] led_enable;
    logic cal_en;
    logic modulation_frequency_select;
    logic thermal_control_bit;
    logic fading_on;
    logic fading_log;
    logic [5:0] fading_time;
    logic [3:0] intensity;
    logic [2:0][10:0] modulation;
    logic [2:0] overflow;
  } led_drive_t;

  typedef struct packed {
    rx_state_t rx_state;
    logic [7:0] rx_id;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sum;
    logic [7:0][7:0] rx_buf;
    logic [5:0] node_addr;
    logic [3:0] membership;
    logic [2:0][23:0] cal;
    logic [7:0] ctrl;
    logic [2:0][7:0] stored;
    logic [2:0][10:0] mod;
    logic [2:0] ovf;
    logic fading_on;
    logic fading_slope;
    logic [5:0] fading_time;
    logic [3:0] intensity;
    logic slope_violation;
    logic [7:0] frames_ok;
    logic [7:0] csum_err;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dec_state_t;
endpackage

// [rtl/calib_row.sv]
// one row of the colour calibration matrix
`timescale 1ns/1ps
module calib_row
  import ledcmd_pkg::*;
(
  input wire logic [23:0] coeff,
  input wire logic [23:0] color,
  output logic [10:0] level,
  output logic overflow
);
  logic [15:0] p0;
  logic [15:0] p1;
  logic [15:0] p2;
  logic [17:0] acc;
  logic [17:0] scaled;

  // coefficient 128 is unity gain; results above the register range saturate
  always_comb begin
    p0 = coeff[7:0] * color[7:0];
    p1 = coeff[15:8] * color[15:8];
    p2 = coeff[23:16] * color[23:16];
    acc = {2'h0, p0} + {2'h0, p1} + {2'h0, p2};
    scaled = acc >> CAL_SHIFT;
    overflow = |scaled[17:11];
    level = overflow ? MOD_MAX : scaled[10:0];
  end
endmodule // calib_row

// [rtl/led_color_command_decoder.sv]
// led colour command decoder with axi4-lite register slave
// Behaviour
// - led control frame switches outputs on/off
// - broad 0: group match, address ignored
// - broad 1: address match, groups ignored
// - sixteen group bits, several may be set
// - addressed led control applies at once
// - calibration off loads colours unchanged
// - calibration on passes colours through matrix
// - policy 00 applies, 01 stores only
// - policy 10 recalls stored, 11 discards
// - full colour frame ends with three colours
// - short colour frame is group-addressed only
// - short colour group from membership low bits
// - short frame mark nibble plus group flags
// - fading slope 0 means logarithmic fading
// - classic checksum over data bytes verified
`timescale 1ns/1ps
module led_color_command_decoder
  import ledcmd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire lin_rx_t rx,
  output led_drive_t drive,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam dec_state_t ST_RST = '{
    rx_state: RX_IDLE,
    node_addr: RST_NODE_ADDR,
    membership: RST_MEMBERSHIP,
    cal: {RST_CAL_ROW3, RST_CAL_ROW2, RST_CAL_ROW1},
    ctrl: RST_CTRL,
    default: '0
  };

  dec_state_t s_reg, s_next;

  function automatic logic [7:0] add_wrap(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction

  // frame decode, from the identifier, the running sum and the buffered data bytes
  logic frame_end, csum_ok, len_ok, frame_good;
  logic is_ctrl, is_color, is_short;
  logic node_hit, group_hit, long_hit, short_hit;
  logic [15:0] group_sel;
  update_policy_t policy;
  logic [2:0][7:0] frame_colors, cal_in;
  logic [2:0][10:0] cal_level, new_mod;
  logic [2:0] cal_ovf, new_ovf;
  logic [7:0] ctrl_byte_in;
  logic [31:0] rd_data, cfg_word, wr_word;
  logic rd_hit;

  assign frame_end = rx.valid && !rx.first && rx.last && (s_reg.rx_state == RX_DATA);
  assign csum_ok = (add_wrap(s_reg.rx_sum, rx.data) == CSUM_ALL_ONES);
  assign is_ctrl = (s_reg.rx_id == ID_LED_CONTROL);
  assign is_color = (s_reg.rx_id == ID_COLOR);
  assign is_short = (s_reg.rx_id == ID_COLOR_SHORT);
  assign len_ok = (is_ctrl && s_reg.rx_cnt == LEN_LED_CONTROL)
               || (is_color && s_reg.rx_cnt == LEN_COLOR)
               || (is_short && s_reg.rx_cnt == LEN_COLOR_SHORT);
  assign frame_good = frame_end && csum_ok && len_ok;
  // group bits 15..8 in third byte
  assign group_sel = {s_reg.rx_buf[IDX_D3], s_reg.rx_buf[IDX_D2]};
  // membership code picks one group bit
  assign group_hit = group_sel[s_reg.membership];
  assign node_hit = (s_reg.rx_buf[IDX_D1][AD_MSB:0] == s_reg.node_addr);
  assign long_hit = s_reg.rx_buf[IDX_D1][ADDR_MODE_BIT] ? node_hit : group_hit;
  // low membership bits select a flag
  assign short_hit = (s_reg.rx_buf[IDX_D4][7:4] == SHORT_MARK)
                  && s_reg.rx_buf[IDX_D4][s_reg.membership[1:0]];
  assign policy = update_policy_t'(s_reg.rx_buf[IDX_D4][POLICY_MSB:POLICY_LSB]);
  assign ctrl_byte_in = s_reg.rx_buf[IDX_D4];

  // colours in the last three data bytes, the first three for a short frame
  always_comb begin
    if (is_short) begin
      frame_colors = {s_reg.rx_buf[IDX_D3], s_reg.rx_buf[IDX_D2], s_reg.rx_buf[IDX_D1]};
    end else begin
      frame_colors = {s_reg.rx_buf[IDX_D8], s_reg.rx_buf[IDX_D7], s_reg.rx_buf[IDX_D6]};
    end
  end

  // recall feeds the stored colours through the same path
  assign cal_in = (is_color && policy == POL_RECALL) ? s_reg.stored : frame_colors;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cal
      calib_row u_row (
        .coeff(s_reg.cal[g]),
        .color({cal_in[2], cal_in[1], cal_in[0]}),
        .level(cal_level[g]),
        .overflow(cal_ovf[g])
      );
      // raw value when calibration is off
      assign new_mod[g] = s_reg.ctrl[CTRL_CAL_EN] ? cal_level[g] : {3'h0, cal_in[g]};
      assign new_ovf[g] = s_reg.ctrl[CTRL_CAL_EN] && cal_ovf[g];
    end
  endgenerate

  assign cfg_word = {20'h00000, s_reg.membership, 2'h0, s_reg.node_addr};

  // unstrobed byte lanes keep the old register contents
  always_comb begin
    unique case (s_reg.aw_addr[7:2])
      REG_NODE_CFG[7:2]: wr_word = cfg_word;
      REG_CAL_ROW1[7:2]: wr_word = {8'h00, s_reg.cal[0]};
      REG_CAL_ROW2[7:2]: wr_word = {8'h00, s_reg.cal[1]};
      REG_CAL_ROW3[7:2]: wr_word = {8'h00, s_reg.cal[2]};
      default: wr_word = 32'h00000000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (s_reg.wstrb[i]) begin
        wr_word[i*8 +: 8] = s_reg.wdata[i*8 +: 8];
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:2])
      REG_NODE_CFG[7:2]: rd_data = cfg_word;
      REG_CAL_ROW1[7:2]: rd_data = {8'h00, s_reg.cal[0]};
      REG_CAL_ROW2[7:2]: rd_data = {8'h00, s_reg.cal[1]};
      REG_CAL_ROW3[7:2]: rd_data = {8'h00, s_reg.cal[2]};
      REG_CONTROL[7:2]: rd_data = {12'h000, s_reg.intensity, s_reg.fading_on,
                                   s_reg.fading_slope, s_reg.fading_time, s_reg.ctrl};
      REG_COLORS[7:2]: rd_data = {8'h00, s_reg.stored[2], s_reg.stored[1], s_reg.stored[0]};
      REG_MOD12[7:2]: rd_data = {5'h00, s_reg.mod[1], 5'h00, s_reg.mod[0]};
      REG_MOD3[7:2]: rd_data = {13'h0000, s_reg.ovf, 5'h00, s_reg.mod[2]};
      REG_STATUS[7:2]: rd_data = {8'h00, s_reg.csum_err, s_reg.frames_ok,
                                  7'h00, s_reg.slope_violation};
      default: begin
        rd_data = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  always_comb begin
    s_next = s_reg;
    // register bus: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      unique case (s_reg.aw_addr[7:2])
        REG_NODE_CFG[7:2]: begin
          s_next.node_addr = wr_word[AD_MSB:0];
          s_next.membership = wr_word[CFG_MEMB_LSB +: 4];
        end
        REG_CAL_ROW1[7:2]: s_next.cal[0] = wr_word[23:0];
        REG_CAL_ROW2[7:2]: s_next.cal[1] = wr_word[23:0];
        REG_CAL_ROW3[7:2]: s_next.cal[2] = wr_word[23:0];
        REG_STATUS[7:2]: begin
          if (s_reg.wstrb[0] && s_reg.wdata[0]) begin
            s_next.slope_violation = 1'b0;
          end
        end
        REG_CONTROL[7:2], REG_COLORS[7:2], REG_MOD12[7:2], REG_MOD3[7:2]: begin
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_data;
      s_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // frame reception; a first byte always restarts, so a cut frame is dropped
    if (rx.valid && rx.first) begin
      s_next.rx_state = RX_DATA;
      s_next.rx_id = rx.data;
      s_next.rx_cnt = 4'h0;
      s_next.rx_sum = 8'h00;
    end else if (rx.valid) begin
      unique case (s_reg.rx_state)
        RX_IDLE: begin
        end
        RX_DATA: begin
          if (rx.last) begin
            s_next.rx_state = RX_IDLE;
          end else begin
            if (s_reg.rx_cnt < BUF_DEPTH) begin
              s_next.rx_buf[s_reg.rx_cnt[2:0]] = rx.data;
            end
            if (s_reg.rx_cnt < RX_CNT_OVF) begin
              s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
            end
            s_next.rx_sum = add_wrap(s_reg.rx_sum, rx.data);
          end
        end
        default: s_next.rx_state = RX_IDLE;
      endcase
    end

    // failed checksum only counts, nothing else moves
    if (frame_end && !csum_ok) begin
      s_next.csum_err = s_reg.csum_err + 8'h01;
    end
    // frame commit comes last so it wins over a same-cycle flag clear
    if (frame_good) begin
      // whole control byte taken at once
      if (is_ctrl && long_hit) begin
        s_next.ctrl = ctrl_byte_in;
        s_next.frames_ok = s_reg.frames_ok + 8'h01;
      end
      if (is_color && long_hit) begin
        s_next.frames_ok = s_reg.frames_ok + 8'h01;
        s_next.fading_time = s_reg.rx_buf[IDX_D4][FTIME_MSB:0];
        s_next.fading_on = s_reg.rx_buf[IDX_D5][FADE_ON_BIT];
        s_next.fading_slope = s_reg.rx_buf[IDX_D5][FADE_SLOPE_BIT];
        s_next.ctrl[CTRL_LEDS_ON] = s_reg.rx_buf[IDX_D5][CLR_LEDS_ON_BIT];
        s_next.intensity = s_reg.rx_buf[IDX_D5][INTENS_MSB:0];
        // a logarithmic colour request is flagged, still obeyed
        if (!s_reg.rx_buf[IDX_D5][FADE_SLOPE_BIT]) begin
          s_next.slope_violation = 1'b1;
        end
        unique case (policy)
          POL_IMMEDIATE: begin
            s_next.stored = frame_colors;
            s_next.mod = new_mod;
            s_next.ovf = new_ovf;
          end
          POL_STORE: s_next.stored = frame_colors;
          POL_RECALL: begin
            s_next.mod = new_mod;
            s_next.ovf = new_ovf;
          end
          POL_DISCARD: begin
          end
        endcase
      end
      if (is_short && short_hit) begin
        s_next.frames_ok = s_reg.frames_ok + 8'h01;
        s_next.stored = frame_colors;
        s_next.mod = new_mod;
        s_next.ovf = new_ovf;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    drive.leds_on = s_reg.ctrl[CTRL_LEDS_ON];
    drive.led_enable = s_reg.ctrl[CTRL_LED3:CTRL_LED1];
    drive.cal_en = s_reg.ctrl[CTRL_CAL_EN];
    drive.modulation_frequency_select = s_reg.ctrl[CTRL_MOD_FREQ];
    drive.thermal_control_bit = s_reg.ctrl[CTRL_THERM];
    drive.fading_on = s_reg.fading_on;
    drive.fading_log = !s_reg.fading_slope;
    drive.fading_time = s_reg.fading_time;
    drive.intensity = s_reg.intensity;
    drive.modulation = s_reg.mod;
    drive.overflow = s_reg.ovf;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ctrl_apply: assert property (frame_good && is_ctrl && long_hit |=>
    s_reg.ctrl == $past(ctrl_byte_in) && drive.leds_on == $past(ctrl_byte_in[CTRL_LEDS_ON]))
    else $error("led control not applied in one cycle");
  a_group_miss: assert property (frame_end && is_ctrl
    && !s_reg.rx_buf[IDX_D1][ADDR_MODE_BIT] && !group_hit |=> $stable(s_reg.ctrl))
    else $error("group miss changed control");
  a_node_miss: assert property (frame_end && is_ctrl
    && s_reg.rx_buf[IDX_D1][ADDR_MODE_BIT] && !node_hit |=> $stable(s_reg.ctrl))
    else $error("address miss changed control");
  a_raw_load: assert property (frame_good && is_color && long_hit
    && policy == POL_IMMEDIATE && !s_reg.ctrl[CTRL_CAL_EN]
    |=> drive.modulation[0] == {3'h0, $past(frame_colors[0])} && drive.overflow == 3'h0)
    else $error("raw colour not loaded");
  a_cal_load: assert property (frame_good && is_color && long_hit
    && policy == POL_IMMEDIATE && s_reg.ctrl[CTRL_CAL_EN]
    |=> drive.modulation[2] == $past(cal_level[2]))
    else $error("calibrated colour not loaded");
  a_store_only: assert property (frame_good && is_color && long_hit
    && policy == POL_STORE |=> $stable(s_reg.mod) && s_reg.stored == $past(frame_colors))
    else $error("store-only changed outputs");
  a_discard_frame: assert property (frame_good && is_color && policy == POL_DISCARD
    |=> $stable(s_reg.stored) && $stable(s_reg.mod))
    else $error("discard changed colours");
  a_short_miss: assert property (frame_end && is_short && !short_hit
    |=> $stable(s_reg.mod) && $stable(s_reg.stored))
    else $error("short frame for other group acted");
  a_bad_csum: assert property (frame_end && !csum_ok
    |=> $stable(s_reg.ctrl) && $stable(s_reg.stored) && $stable(s_reg.mod))
    else $error("frame with bad checksum acted");
  a_slope_log: assert property (frame_good && is_color && long_hit
    && !s_reg.rx_buf[IDX_D5][FADE_SLOPE_BIT] |=> drive.fading_log && s_reg.slope_violation)
    else $error("slope 0 not logarithmic");

  c_ctrl_group: cover property (frame_good && is_ctrl && !s_reg.rx_buf[IDX_D1][ADDR_MODE_BIT]
    && group_hit);
  c_color_recall: cover property (frame_good && is_color && long_hit && policy == POL_RECALL);
  c_short_hit: cover property (frame_good && is_short && short_hit);
  c_bus_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // led_color_command_decoder

// [tb/lin_master_model.sv]
// frame source that stands in for the bus master feeding the decoder
`timescale 1ns/1ps
module lin_master_model
  import ledcmd_pkg::*;
(
  input wire logic aclk,
  output lin_rx_t rx
);
  initial rx = '0;
  task automatic send(input logic [7:0] id, input logic [63:0] d, input int n, input int gap,
                      input logic bad);
    logic [8:0] s;
    logic [7:0] c;
    logic [7:0] b;
    s = '0;
    for (int i = 1; i <= n; i++) begin
      s = s[7:0] + d[8*(n-i) +: 8] + s[8];
    end
    c = ~(s[7:0] + s[8]) ^ {7'h00, bad};
    for (int i = 0; i <= n + 1; i++) begin
      b = (i == 0) ? id : (i > n) ? c : d[8*(n-i) +: 8];
      @(posedge aclk);
      rx.valid <= 1'b1;
      rx.first <= (i == 0);
      rx.last <= (i == n + 1);
      rx.data <= b;
      // idle data shows inverse so stale bytes never look valid
      repeat (gap) begin
        @(posedge aclk);
        rx.valid <= 1'b0;
        rx.data <= ~b;
      end
    end
    @(posedge aclk);
    rx <= '{valid: 1'b0, first: 1'b0, last: 1'b0, data: ~b};
  endtask
endmodule // lin_master_model

// [tb/tb_led_color_command_decoder.sv]
// self-checking bench for the led colour command decoder
`timescale 1ns/1ps
module tb_led_color_command_decoder
  import ledcmd_pkg::*;
;
  logic aclk, aresetn;
  lin_rx_t rx;
  led_drive_t drive;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total, comparisons;

  led_color_command_decoder u_led_color_command_decoder (.aclk, .aresetn, .rx, .drive,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lin_master_model u_lin_master_model (.aclk, .rx);

  always #20 aclk = ~aclk;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // full colour frames come with gaps between bytes, the rest back to back
  task automatic frm(input logic [7:0] id, input logic [63:0] d, input int n, input logic bad);
    u_lin_master_model.send(id, d, n, (id == ID_COLOR) ? 2 : 0, bad);
    repeat (2) @(posedge aclk);
  endtask

  function automatic logic [6:0] cb();
    return {drive.cal_en, drive.modulation_frequency_select, drive.leds_on,
            drive.thermal_control_bit, drive.led_enable};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge aclk);
    err_total++;
    give_verdict();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_CONTROL, 32'h00000001, RESP_OKAY); // reset control byte
    axw(REG_NODE_CFG, 32'h00000605, RESP_OKAY); // node address
    axr(REG_NODE_CFG, 32'h00000605, RESP_OKAY); // node address
    axw(8'h24, 32'h00000001, RESP_SLVERR);
    axr(8'h24, 32'h00000000, RESP_SLVERR);
    axw(REG_CONTROL, 32'hFFFFFFFF, RESP_OKAY);
    $display("test registers done");
    frm(ID_LED_CONTROL, {8'hC5, 8'h00, 8'h00, 8'h2F}, 4, 1'b0); // own address
    chk(cb(), 7'h17); // outputs switched
    axr(REG_CONTROL, 32'h0000002F, RESP_OKAY); // control byte
    frm(ID_LED_CONTROL, {8'hC6, 8'h00, 8'h00, 8'h01}, 4, 1'b0); // wrong address
    frm(ID_LED_CONTROL, {8'hC4, 8'hFF, 8'hFF, 8'h01}, 4, 1'b0); // groups ignored
    frm(ID_LED_CONTROL, {8'hC5, 8'h00, 8'h00, 8'h01}, 4, 1'b1); // bad checksum
    chk(cb(), 7'h17); // settings kept
    frm(ID_LED_CONTROL, {8'h46, 8'h40, 8'h00, 8'h3B}, 4, 1'b0); // group six
    chk(cb(), 7'h1D); // group match
    frm(ID_LED_CONTROL, {8'h45, 8'hBF, 8'hFF, 8'h01}, 4, 1'b0); // group miss
    chk(cb(), 7'h1D); // settings kept
    $display("test control frames done");
    frm(ID_COLOR, {8'hC5, 8'h00, 8'h00, 8'h0A, 8'hF9, 8'h11, 8'h22, 8'h33}, 8, 1'b0);
    chk(drive.modulation, {11'h033, 11'h022, 11'h011}); // immediate load
    chk({drive.fading_on, drive.fading_log, drive.fading_time, drive.intensity},
        {1'b1, 1'b0, 6'h0A, 4'h9}); // fading fields
    frm(ID_COLOR, {8'hC5, 8'h00, 8'h00, 8'h4A, 8'hF9, 8'h44, 8'h55, 8'h66}, 8, 1'b0); // store
    chk(drive.modulation, {11'h033, 11'h022, 11'h011}); // outputs held
    axr(REG_COLORS, 32'h00665544, RESP_OKAY); // colours stored
    frm(ID_COLOR, {8'hC5, 8'h00, 8'h00, 8'h8A, 8'hF9, 8'h77, 8'h88, 8'h99}, 8, 1'b0);
    chk(drive.modulation, {11'h066, 11'h055, 11'h044}); // stored recalled
    frm(ID_COLOR, {8'hC5, 8'h00, 8'h00, 8'hCA, 8'hF9, 8'hAA, 8'hBB, 8'hCC}, 8, 1'b0);
    chk(drive.modulation, {11'h066, 11'h055, 11'h044}); // discard keeps outputs
    axr(REG_COLORS, 32'h00665544, RESP_OKAY); // discard keeps store
    frm(ID_COLOR, {8'h40, 8'h40, 8'h00, 8'h0A, 8'hB9, 8'h11, 8'h22, 8'h33}, 8, 1'b0);
    chk(drive.fading_log, 1'b1); // logarithmic slope
    axr(REG_CONTROL, 32'h00098A3B, RESP_OKAY); // fields read back
    axr(REG_STATUS, 32'h00010701, RESP_OKAY); // slope flag and counts
    axw(REG_STATUS, 32'h00000001, RESP_OKAY); // flag cleared
    axr(REG_STATUS, 32'h00010700, RESP_OKAY); // flag cleared
    $display("test colour frames done");
    frm(ID_COLOR_SHORT, {8'hDD, 8'hEE, 8'h11, 8'hF4}, 4, 1'b0); // group c
    chk(drive.modulation, {11'h011, 11'h0EE, 11'h0DD}); // short applied
    frm(ID_COLOR_SHORT, {8'h22, 8'h22, 8'h22, 8'hFB}, 4, 1'b0); // other groups
    frm(ID_COLOR_SHORT, {8'h22, 8'h22, 8'h22, 8'h74}, 4, 1'b0); // bad mark
    chk(drive.modulation, {11'h011, 11'h0EE, 11'h0DD}); // outputs held
    $display("test short frames done");
    axw(REG_CAL_ROW1, 32'h00000040, RESP_OKAY); // row one
    axw(REG_CAL_ROW2, 32'h0000FF00, RESP_OKAY); // row two
    frm(ID_LED_CONTROL, {8'hC5, 8'h00, 8'h00, 8'hEF}, 4, 1'b0); // enable matrix
    chk(cb(), 7'h77); // calibration and frequency bits
    frm(ID_COLOR, {8'hC5, 8'h00, 8'h00, 8'h0A, 8'hF9, 8'h80, 8'hFF, 8'h20}, 8, 1'b0);
    chk(drive.modulation, {11'h020, 11'h1FC, 11'h040}); // matrix result
    chk(drive.overflow, 3'h0); // no saturation
    axr(REG_MOD12, 32'h01FC0040, RESP_OKAY); // modulation registers
    axr(REG_MOD3, 32'h00000020, RESP_OKAY); // modulation registers
    $display("test calibration done");
    give_verdict();
  end
endmodule // tb_led_color_command_decoder
